// [hw/dci_cfg.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes a 250 MHz core clock and a byte-wide register port.
`ifndef DCI_CFG_SVH
`define DCI_CFG_SVH

// Register offsets.
`define DCI_OFS_CTRL 1'h0
`define DCI_OFS_CODE 1'h1

// Control register field positions.
`define DCI_BIT_ENABLE 0
`define DCI_BIT_PIN_OUTPUT_BUFFER_ENABLE 6
`define DCI_BIT_RUNSTBY 7

// Mask of implemented control bits.
`define DCI_CTRL_MASK 8'hc1

// Reset values.
`define DCI_CTRL_RST 8'h00
`define DCI_CODE_RST 8'h00

// Core clock rate in MHz.
`define DCI_CLK_MHZ 250

// Analog start-up time after wake, in ns.
`define DCI_STARTUP_NS 1000

// Start-up cycles: least time, so rounded up.
`define DCI_STARTUP_CYC \
  ((`DCI_STARTUP_NS * `DCI_CLK_MHZ + 999) / 1000)

`endif

// [hw/dci_pkg.sv]
// Types shared by the converter control block.
// Assumes the configuration header is included where constants are needed.
package dci_pkg;

  // Power state of the analog core as steered by the control logic.
  typedef enum logic [1:0] {
    DCI_OFF,
    DCI_WAKE,
    DCI_RUN
  } dci_pwr_t;

  // Signals toward the analog core, kept together.
  typedef struct packed {
    logic core_on;
    logic buf_on;
    logic internal_valid;
    logic convert;
    logic [7:0] code;
  } dci_analog_t;

  // Whole state of the control module.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] code;
    logic [7:0] rdata;
    dci_pwr_t pwr;
    logic [15:0] wait_cnt;
    logic pend;
    logic stby_s1;
    logic stby_s2;
    logic pdn_s1;
    logic pdn_s2;
    dci_analog_t ana;
  } dci_state_t;

endpackage : dci_pkg

// [hw/dci_ctrl.sv]
// Control logic of one 8-bit resistor-string converter instance.
// Assumes sleep requests come from another domain and are synchronised.
//
// Function
// - Control bit 0 enables the converter.
// - Enabled: code write launches conversion two cycles on, once running.
// - Disabled: code write only stores value.
// - Writing enable one converts held code.
// - Control bit 6 drives output buffer to pin.
// - Only instance zero has a pin driver.
// - Internal output valid while enabled core is in run state.
// - Run-in-standby bit 7 keeps standby operation.
// - Standby without run-in-standby powers all off.
// - Wake restores core, buffer; start-up delay.
// - Power-down sleep always powers all off.
// - Control at 0x00, resets zero, bits 7,6,0.
// - Code register at 0x01, resets zero.
// - Debug halt leaves behaviour unchanged.
`timescale 1ns/1ps
`include "dci_cfg.svh"

module dci_ctrl #(
  // Instance number; only instance zero owns a pin driver.
  parameter int INSTANCE = 0,
  // Start-up wait after leaving a sleep state, in cycles.
  parameter logic [15:0] STARTUP_CYCLES = 16'(`DCI_STARTUP_CYC)
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic STANDBY,
  input wire logic POWERDOWN,
  input wire logic DEBUG_HALT,
  output logic CORE_ON,
  output logic BUF_ON,
  output logic INTERNAL_VALID,
  output logic CONVERT,
  output logic [7:0] CODE
);

  // Present state and its next value.
  dci_pkg::dci_state_t st_reg;
  dci_pkg::dci_state_t st_next;

  // Helper decode of the two register addresses.
  function automatic logic hit(input logic a, input logic ofs);
    hit = (a == ofs);
  endfunction : hit

  // Debug halt is read on purpose by nothing: behaviour is unchanged.
  logic unused_halt;
  assign unused_halt = DEBUG_HALT;

  // Next-state logic for the whole block.
  always_comb begin
    logic sleep_off;
    logic wr_ctrl;
    logic wr_code;
    logic en_new;
    sleep_off = 1'b0;
    wr_ctrl = 1'b0;
    wr_code = 1'b0;
    en_new = 1'b0;
    st_next = st_reg;
    // Two-stage synchronisers for the sleep requests.
    st_next.stby_s1 = STANDBY;
    st_next.stby_s2 = st_reg.stby_s1;
    st_next.pdn_s1 = POWERDOWN;
    st_next.pdn_s2 = st_reg.pdn_s1;
    st_next.ana.convert = 1'b0;
    st_next.rdata = 8'h00;
    // Register writes; address decode by if chain.
    if (WR && hit(ADDR, `DCI_OFS_CTRL)) begin
      wr_ctrl = 1'b1;
      st_next.ctrl = WDATA & `DCI_CTRL_MASK;
    end else if (WR && hit(ADDR, `DCI_OFS_CODE)) begin
      wr_code = 1'b1;
      st_next.code = WDATA;
    end
    // Register reads, data in the following cycle.
    if (RD && hit(ADDR, `DCI_OFS_CTRL)) begin
      st_next.rdata = st_reg.ctrl & `DCI_CTRL_MASK;
    end else if (RD && hit(ADDR, `DCI_OFS_CODE)) begin
      st_next.rdata = st_reg.code;
    end
    en_new = st_next.ctrl[`DCI_BIT_ENABLE];
    // Conversion requests: data write while enabled, or enable write.
    if (wr_code && st_reg.ctrl[`DCI_BIT_ENABLE]) begin
      st_next.pend = 1'b1;
    end else if (wr_ctrl && WDATA[`DCI_BIT_ENABLE]) begin
      st_next.pend = 1'b1;
    end
    // A code write while disabled only stores the value.
    if (!en_new) begin
      st_next.pend = 1'b0;
    end
    // Sleep that forces the core off.
    sleep_off = st_reg.pdn_s2 ||
      (st_reg.stby_s2 && !st_reg.ctrl[`DCI_BIT_RUNSTBY]);
    // Power state machine for the analog core.
    case (st_reg.pwr)
      dci_pkg::DCI_OFF: begin
        if (en_new && !sleep_off) begin
          st_next.pwr = dci_pkg::DCI_WAKE;
          st_next.wait_cnt = STARTUP_CYCLES;
        end
      end
      dci_pkg::DCI_WAKE: begin
        // Start-up time elapses before a conversion is issued.
        if (!en_new || sleep_off) begin
          st_next.pwr = dci_pkg::DCI_OFF;
        end else if (st_reg.wait_cnt <= 16'h0001) begin
          st_next.pwr = dci_pkg::DCI_RUN;
          st_next.wait_cnt = 16'h0000;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt - 16'h0001;
        end
      end
      dci_pkg::DCI_RUN: begin
        if (!en_new || sleep_off) begin
          st_next.pwr = dci_pkg::DCI_OFF;
        end else if (st_reg.pend) begin
          st_next.ana.convert = 1'b1;
          st_next.ana.code = st_reg.code;
          st_next.pend = st_next.pend && wr_code;
        end
      end
      default: begin
        st_next.pwr = dci_pkg::DCI_OFF;
      end
    endcase
    // Wake after a stopped standby re-converts the held code.
    if (st_reg.pwr == dci_pkg::DCI_RUN && sleep_off && en_new) begin
      st_next.pend = 1'b1;
    end
    st_next.ana.core_on = (st_next.pwr != dci_pkg::DCI_OFF);
    st_next.ana.internal_valid =
      (st_next.pwr == dci_pkg::DCI_RUN);
    st_next.ana.buf_on = (INSTANCE == 0) && st_next.ana.core_on &&
      st_next.ctrl[`DCI_BIT_PIN_OUTPUT_BUFFER_ENABLE];
  end

  // State register with synchronous reset.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_reg <= '0;
      st_reg.ctrl <= `DCI_CTRL_RST;
      st_reg.code <= `DCI_CODE_RST;
      st_reg.pwr <= dci_pkg::DCI_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flip-flops.
  assign RDATA = st_reg.rdata;
  assign CORE_ON = st_reg.ana.core_on;
  assign BUF_ON = st_reg.ana.buf_on;
  assign INTERNAL_VALID = st_reg.ana.internal_valid;
  assign CONVERT = st_reg.ana.convert;
  assign CODE = st_reg.ana.code;

  // Sequence of a code write while running.
  sequence s_code_wr_run;
    WR && ADDR == `DCI_OFS_CODE && st_reg.pwr == dci_pkg::DCI_RUN &&
      st_reg.ctrl[`DCI_BIT_ENABLE] && !st_reg.pend;
  endsequence

  // Conversion follows the write within two cycles.
  AST_CODE_LAUNCH: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    s_code_wr_run |-> ##[1:2] CONVERT)
    else $error("code write while running did not convert");

  // A code write while disabled never converts.
  AST_DISABLED_STORE: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    (WR && ADDR == `DCI_OFS_CODE && !st_reg.ctrl[`DCI_BIT_ENABLE] &&
      !(st_reg.pwr == dci_pkg::DCI_RUN)) |=> !CONVERT)
    else $error("conversion while disabled");

  // Enable write to an already running core leads to conversion within two cycles.
  AST_ENABLE_START: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    (WR && ADDR == `DCI_OFS_CTRL && WDATA[0] &&
      st_reg.pwr == dci_pkg::DCI_RUN) |-> ##[1:2] CONVERT)
    else $error("enable write did not convert");

  // Buffer never on without enable bit or on other instances.
  AST_BUF_GATE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    BUF_ON |-> (st_reg.ctrl[`DCI_BIT_PIN_OUTPUT_BUFFER_ENABLE] && CORE_ON &&
      INSTANCE == 0))
    else $error("buffer on without enable");

  // Internal output valid only while enabled.
  AST_INT_VALID: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    INTERNAL_VALID |-> st_reg.ctrl[`DCI_BIT_ENABLE])
    else $error("internal output valid while disabled");

  // Power-down turns the core off within one cycle.
  AST_PDN_OFF: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    st_reg.pdn_s2 |=> !CORE_ON && !BUF_ON)
    else $error("core on in power-down");

  // Standby with run-in-standby keeps a running core on.
  AST_STBY_RUN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_reg.stby_s2 && !st_reg.pdn_s2 && st_reg.ctrl[7] &&
      st_reg.ctrl[0] && st_reg.pwr == dci_pkg::DCI_RUN && !WR)
      |=> CORE_ON)
    else $error("core stopped in standby with run-in-standby");

  // Standby without run-in-standby stops the core.
  AST_STBY_STOP: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_reg.stby_s2 && !st_reg.ctrl[7]) |=> !CORE_ON)
    else $error("core running in standby");

  // Control write strobe as seen on the register port.
  sequence s_ctrl_wr;
    WR && ADDR == `DCI_OFS_CTRL;
  endsequence

  // Code write strobe as seen on the register port.
  sequence s_code_wr;
    WR && ADDR == `DCI_OFS_CODE;
  endsequence

  // Control read strobe as seen on the register port.
  sequence s_ctrl_rd;
    RD && ADDR == `DCI_OFS_CTRL;
  endsequence

  // Code read strobe as seen on the register port.
  sequence s_code_rd;
    RD && ADDR == `DCI_OFS_CODE;
  endsequence

  // A control read shows zero in bits 5..1; code reads carry any value.
  AST_RSVD_ZERO: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    s_ctrl_rd |=> (RDATA[5:1] == 5'h00))
    else $error("reserved bits not zero");

  // A control write keeps only the implemented bits.
  AST_CTRL_STORE: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    s_ctrl_wr |=> (st_reg.ctrl == ($past(WDATA) & `DCI_CTRL_MASK)))
    else $error("control write stored wrongly");

  // A code write always stores the value, enabled or not.
  AST_CODE_STORE: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    s_code_wr |=> (st_reg.code == $past(WDATA)))
    else $error("code write stored wrongly");

  // A control read returns the stored control value next cycle.
  AST_RD_CTRL: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    s_ctrl_rd |=> (RDATA == $past(st_reg.ctrl)))
    else $error("control read data wrong");

  // A code read returns the stored code next cycle.
  AST_RD_CODE: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    s_code_rd |=> (RDATA == $past(st_reg.code)))
    else $error("code read data wrong");

  // Read data stay zero when no read was made.
  AST_RD_IDLE: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    !RD |=> (RDATA == 8'h00))
    else $error("read data without a read");

  // A start pulse only leaves a running, internally usable core.
  AST_CONV_ON: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    CONVERT |-> (INTERNAL_VALID && CORE_ON))
    else $error("start pulse without running core");

  // A start pulse carries the code held in the cycle before.
  AST_CONV_CODE: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    CONVERT |-> (CODE == $past(st_reg.code)))
    else $error("start pulse with wrong code");

  // The converted code only changes together with a start pulse.
  AST_CODE_HOLD: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    !CONVERT |-> $stable(CODE))
    else $error("converted code changed without start");

  // A core that is off offers nothing and starts nothing.
  AST_OFF_QUIET: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    !CORE_ON |-> (!INTERNAL_VALID && !BUF_ON && !CONVERT))
    else $error("activity while core off");

  // Running is not reached while start-up time remains.
  AST_WAKE_HOLD: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (st_reg.pwr == dci_pkg::DCI_WAKE && st_reg.wait_cnt > 16'h0001)
      |=> (st_reg.pwr != dci_pkg::DCI_RUN))
    else $error("start-up time cut short");

  // Powering the core loads the full start-up count.
  AST_WAKE_LOAD: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    $rose(CORE_ON) |-> (st_reg.wait_cnt == STARTUP_CYCLES))
    else $error("start-up count not loaded");

  // The output becomes usable only at the end of start-up.
  AST_VALID_AFTER_WAKE: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    $rose(INTERNAL_VALID) |-> ($past(st_reg.pwr) == dci_pkg::DCI_WAKE))
    else $error("output usable without start-up");

  // A sleep stop of a running core marks the held code for reconversion.
  AST_SLEEP_PEND: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (st_reg.pwr == dci_pkg::DCI_RUN && st_reg.pdn_s2 &&
      st_reg.ctrl[`DCI_BIT_ENABLE] && !WR) |=> st_reg.pend)
    else $error("no reconversion marked after sleep stop");

  // Writing the enable bit to zero turns the core off.
  AST_DIS_OFF: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (s_ctrl_wr ##0 !WDATA[`DCI_BIT_ENABLE]) |=> !CORE_ON)
    else $error("core still on after disable");

  // Writing the enable bit to one outside sleep powers the core.
  AST_EN_ON: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (s_ctrl_wr ##0 (WDATA[`DCI_BIT_ENABLE] && !st_reg.pdn_s2 &&
      !st_reg.stby_s2)) |=> CORE_ON)
    else $error("core not powered after enable");

  // Instances other than zero never drive a pin.
  AST_NO_PIN_OTHER: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (INSTANCE != 0) |-> !BUF_ON)
    else $error("pin buffer on a non-pin instance");

  // On instance zero the buffer follows its enable while powered.
  AST_BUF_FOLLOW: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CORE_ON && st_reg.ctrl[`DCI_BIT_PIN_OUTPUT_BUFFER_ENABLE] && INSTANCE == 0) |-> BUF_ON)
    else $error("pin buffer off although enabled");

endmodule : dci_ctrl

// [tb/dci_core_model.sv]
// Behavioural model of the analog converter core behind the control block.
// Assumes it shares the core clock with the control block.
`timescale 1ns/1ps

module dci_core_model (
  input wire logic CORE_CLK,
  input wire logic CORE_ON,
  input wire logic CONVERT,
  input wire logic [7:0] CODE,
  output logic [7:0] level,
  output int n_conv
);
  // Level held by the resistor string and the count of started conversions.
  // The reference is chosen outside this block, so the level is a bare code.
  initial begin
    level = 8'h00;
    n_conv = 0;
  end

  // A start pulse only takes effect while the core is powered.
  always @(posedge CORE_CLK) begin
    if (CONVERT === 1'b1 && CORE_ON === 1'b1) begin
      level <= CODE;
      n_conv <= n_conv + 1;
    end
  end
endmodule : dci_core_model

// [tb/tb_top.sv]
// Self-checking bench for one converter control instance.
// Assumes the control block, its package and the core model are compiled.
`timescale 1ns/1ps

module tb_top;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic ADDR = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic STANDBY = 1'b0;
  logic POWERDOWN = 1'b0;
  logic DEBUG_HALT = 1'b0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA, CODE, level;
  logic CORE_ON, BUF_ON, INTERNAL_VALID, CONVERT;
  int miscompares = 0;
  int n_checks = 0;
  int n_conv, n0;

  // Clock of 4 ns period.
  always #2 CORE_CLK = ~CORE_CLK;

  // Short start-up so that wake sequences stay brief.
  dci_ctrl #(.INSTANCE(0), .STARTUP_CYCLES(16'h0004)) u_dci_ctrl (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STANDBY(STANDBY),
    .POWERDOWN(POWERDOWN), .DEBUG_HALT(DEBUG_HALT), .CORE_ON(CORE_ON),
    .BUF_ON(BUF_ON), .INTERNAL_VALID(INTERNAL_VALID), .CONVERT(CONVERT),
    .CODE(CODE));
  dci_core_model u_dci_core_model (.CORE_CLK(CORE_CLK), .CORE_ON(CORE_ON),
    .CONVERT(CONVERT), .CODE(CODE), .level(level), .n_conv(n_conv));

  // Compares one value and counts it.
  task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk

  // One-cycle register write.
  task wr(input logic a, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask : wr

  // One-cycle read; data are looked at in the following cycle only.
  task rd(input logic a, input logic [7:0] exp, input string s);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp, s);
  endtask : rd

  // Waits a bounded time for a start pulse and checks its code.
  task conv(input logic [7:0] exp);
    int i;
    i = 0;
    do begin
      @(posedge CORE_CLK);
      #1;
      i++;
    end while (CONVERT !== 1'b1 && i < 20);
    chk(CONVERT, 8'h01, "start pulse");
    chk(CODE, exp, "code");
  endtask : conv

  // Lets n cycles pass, then checks the core and buffer power.
  task settle(input int n, input logic on, input logic bo, input string s);
    repeat (n) @(posedge CORE_CLK);
    #1;
    chk(CORE_ON, on, s);
    chk(BUF_ON, bo, s);
  endtask : settle

  // Prints the counts and the verdict, then ends the run.
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    rd(1'b0, 8'h00, "ctrl reset");
    rd(1'b1, 8'h00, "code reset");
    n0 = n_conv;
    wr(1'b1, 8'h5a);
    settle(8, 1'b0, 1'b0, "off");
    chk(8'(n_conv - n0), 8'h00, "stored only");
    rd(1'b1, 8'h5a, "code");
    $display("test reset and store done");
    wr(1'b0, 8'h3f);
    conv(8'h5a);
    rd(1'b0, 8'h01, "ctrl");
    chk(INTERNAL_VALID, 8'h01, "internal");
    chk(BUF_ON, 8'h00, "buffer off");
    wr(1'b1, 8'ha5);
    conv(8'ha5);
    wr(1'b0, 8'h41);
    settle(4, 1'b1, 1'b1, "buffer on");
    $display("test enable and convert done");
    @(posedge CORE_CLK) STANDBY <= 1'b1;
    settle(6, 1'b0, 1'b0, "standby stop");
    chk(INTERNAL_VALID, 8'h00, "internal stopped");
    @(posedge CORE_CLK) STANDBY <= 1'b0;
    conv(8'ha5);
    settle(1, 1'b1, 1'b1, "wake");
    wr(1'b0, 8'hc1);
    @(posedge CORE_CLK) STANDBY <= 1'b1;
    settle(6, 1'b1, 1'b1, "run in standby");
    @(posedge CORE_CLK) POWERDOWN <= 1'b1;
    settle(6, 1'b0, 1'b0, "power down");
    @(posedge CORE_CLK) POWERDOWN <= 1'b0;
    STANDBY <= 1'b0;
    conv(8'ha5);
    $display("test sleep done");
    @(posedge CORE_CLK) DEBUG_HALT <= 1'b1;
    wr(1'b1, 8'h3c);
    conv(8'h3c);
    settle(2, 1'b1, 1'b1, "halt");
    chk(level, 8'h3c, "core level");
    @(posedge CORE_CLK) DEBUG_HALT <= 1'b0;
    wr(1'b0, 8'h00);
    settle(4, 1'b0, 1'b0, "disable");
    chk(INTERNAL_VALID, 8'h00, "internal off");
    $display("test halt and disable done");
    close_out();
  end

  // Cuts a hang short well beyond the expected run of about 100 cycles.
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
